// ---- src/nfh_map.svh ----
// timing counts and command codes for the nand host sequencer
`ifndef NFH_MAP_SVH
`define NFH_MAP_SVH
`define NFH_CMD_READ      8'h00
`define NFH_CMD_READ_GO   8'h30
`define NFH_CMD_PROG      8'h80
`define NFH_CMD_COLCHG    8'h85
`define NFH_CMD_PROG_GO   8'h10
`define NFH_CMD_MPROG     8'h11
`define NFH_CMD_CPROG     8'h15
`define NFH_CMD_ERASE     8'h60
`define NFH_CMD_ERASE_GO  8'hD0
`define NFH_CMD_STATUS    8'h70
`define NFH_CMD_STATUS2   8'h71
`define NFH_CMD_RESET     8'hFF
`define NFH_ST_FAIL_BIT   0
`define NFH_ST_RDY_BIT    6
`define NFH_ST_WP_BIT     7
`define NFH_BAD_MARK      8'h00
`define NFH_PAD_BYTE      8'hFF
`define NFH_MAX_PARTIAL   3'h4
`define NFH_ADDR_CYCLES   3'h5
`define NFH_STROBE_CYC    4'h3
`define NFH_BLOCKS        12'h800
`define NFH_PAGES         7'h40
`endif

// ---- src/nfh_pkg.sv ----
// types for the nand host sequencer
package nfh_pkg;
	typedef enum logic [2:0] {
		NFH_OP_READ,
		NFH_OP_PROG,
		NFH_OP_ERASE,
		NFH_OP_STATUS,
		NFH_OP_RESET,
		NFH_OP_SCAN
	} nfh_op_e;
	typedef struct packed {
		nfh_op_e     op;
		logic [10:0] block;
		logic [5:0]  page;
		logic [12:0] col;
		logic        partial;
	} nfh_req_s;
	typedef struct packed {
		logic       cle;
		logic       ale;
		logic       we_n;
		logic       re_n;
		logic       ce_n;
		logic       wp_n;
		logic [7:0] dq_out;
		logic       dq_oe;
	} nfh_pins_s;
endpackage

// ---- src/nfh_host.sv ----
// host sequencer that drives a nand flash through its pins
`include "nfh_map.svh"
`timescale 1ns/100ps
`default_nettype none
module nfh_host (
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic          clk_en,
	input  wire nfh_pkg::nfh_req_s req,
	input  wire logic          req_valid,
	output logic               req_ready,
	input  wire logic [7:0]    wr_data,
	input  wire logic          wr_last,
	output logic               wr_take,
	output logic [7:0]         rd_data,
	output logic               rd_valid,
	input  wire logic          rd_last,
	output logic               done,
	output logic               fail,
	output logic               refused,
	output logic               bad_block,
	output logic               prot,
	output nfh_pkg::nfh_pins_s pins,
	input  wire logic [7:0]    dq_in,
	input  wire logic          ready_busy_n
);
	import nfh_pkg::*;
	typedef enum {
		S_INIT, S_IDLE, S_CMD, S_ADDR, S_WAIT, S_WDATA, S_RDATA,
		S_CMD2, S_STAT, S_DONE
	} nfh_st_e;
	nfh_st_e   st;
	nfh_req_s  cur;
	logic [7:0] cmd;
	logic [2:0] acnt;
	logic [3:0] tcnt;
	logic [1:0] phase;
	logic [7:0] dq_s1, dq_s;
	logic       rb_s1, rb_s;
	logic [2048-1:0] bad_tab; // covers every block
	logic [5:0]  last_page [0:2047];
	logic [2047:0] page_used;
	logic [2:0]  part_cnt;
	logic [5:0]  part_page;
	logic [10:0] part_blk;
	logic       stat_after;
	function automatic logic [7:0] addr_byte(input nfh_req_s r,
		input logic [2:0] i);
		logic [16:0] row;
		row = {r.block, r.page};
		case (i)
			3'h0: addr_byte = r.col[7:0];
			3'h1: addr_byte = {3'h0, r.col[12:8]};
			3'h2: addr_byte = row[7:0];
			3'h3: addr_byte = row[15:8];
			default: addr_byte = {7'h00, row[16]};
		endcase
	endfunction
	wire [10:0] rq_blk = req.block;
	wire        is_bad = bad_tab[rq_blk];
	// ascending pages only; a partial write repeats the same page
	wire        order_ok = !page_used[rq_blk] ||
		(req.page > last_page[rq_blk]) ||
		(req.partial && req.page == last_page[rq_blk]);
	wire        part_ok = !(req.partial && part_blk == rq_blk &&
		part_page == req.page && part_cnt >= `NFH_MAX_PARTIAL);
	wire        busy_ok = rb_s || req.op == NFH_OP_STATUS ||
		req.op == NFH_OP_RESET;
	wire        op_ok = !(req.op == NFH_OP_ERASE && is_bad) &&
		!(req.op == NFH_OP_PROG && (is_bad || !order_ok || !part_ok));
	wire        accept = st == S_IDLE && req_valid && busy_ok && op_ok;
	wire        reject = st == S_IDLE && req_valid && busy_ok && !op_ok;
	wire        tick = tcnt == `NFH_STROBE_CYC;
	// single-byte command set; unknown codes never leave this table
	wire [7:0]  first_cmd =
		req.op == NFH_OP_PROG   ? `NFH_CMD_PROG :
		req.op == NFH_OP_ERASE  ? `NFH_CMD_ERASE :
		req.op == NFH_OP_STATUS ? `NFH_CMD_STATUS :
		req.op == NFH_OP_RESET  ? `NFH_CMD_RESET : `NFH_CMD_READ;
	wire [7:0]  second_cmd = cur.op == NFH_OP_PROG ? `NFH_CMD_PROG_GO :
		cur.op == NFH_OP_ERASE ? `NFH_CMD_ERASE_GO : `NFH_CMD_READ_GO;
	// decoded from the byte captured while read enable was still low
	wire        st_fail = rd_data[`NFH_ST_FAIL_BIT];
	wire        st_rdy = rd_data[`NFH_ST_RDY_BIT];
	always_ff @(posedge clock) begin
		if (clk_en) begin
			dq_s1 <= dq_in;
			dq_s <= dq_s1;
			rb_s1 <= ready_busy_n;
			rb_s <= rb_s1;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st <= S_INIT;
			cur <= '0;
			cmd <= 8'h00;
			acnt <= 3'h0;
			tcnt <= 4'h0;
			phase <= 2'h0;
			pins <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
				ce_n: 1'b1, wp_n: 1'b0, dq_out: 8'h00, dq_oe: 1'b0};
			req_ready <= 1'b0;
			wr_take <= 1'b0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			done <= 1'b0;
			fail <= 1'b0;
			refused <= 1'b0;
			bad_block <= 1'b0;
			prot <= 1'b0;
			bad_tab <= '0;
			page_used <= '0;
			part_cnt <= 3'h0;
			part_page <= 6'h00;
			part_blk <= 11'h000;
			stat_after <= 1'b0;
		end else if (clk_en) begin
			wr_take <= 1'b0;
			rd_valid <= 1'b0;
			done <= 1'b0;
			refused <= reject;
			tcnt <= tick ? 4'h0 : tcnt + 4'h1;
			case (st)
			// wait out power-on busy before any array command
			S_INIT: begin
				pins.wp_n <= 1'b1; // low would abort work
				if (rb_s) begin
					st <= S_IDLE;
					req_ready <= 1'b1;
				end
			end
			S_IDLE: begin
				if (accept) begin
					cur <= req;
					cmd <= first_cmd;
					st <= S_CMD;
					req_ready <= 1'b0;
					tcnt <= 4'h0;
					phase <= 2'h0;
					pins.ce_n <= 1'b0;
					fail <= 1'b0;
					bad_block <= 1'b0;
					stat_after <= 1'b0;
				end
			end
			S_CMD, S_CMD2: begin
				if (tick) begin
					phase <= phase + 2'h1;
					case (phase)
					2'h0: begin
						pins.cle <= 1'b1;
						pins.dq_out <= st == S_CMD ? cmd : second_cmd;
						pins.dq_oe <= 1'b1;
						pins.we_n <= 1'b0;
					end
					2'h1: pins.we_n <= 1'b1;
					default: begin
						pins.cle <= 1'b0;
						pins.dq_oe <= 1'b0;
						phase <= 2'h0;
						acnt <= 3'h0;
						if (st == S_CMD2 || cmd == `NFH_CMD_STATUS ||
							cmd == `NFH_CMD_RESET)
							st <= S_WAIT;
						else
							st <= S_ADDR;
					end
					endcase
				end
			end
			// five cycles, three for erase; a sixth would be dropped anyway
			S_ADDR: begin
				if (tick) begin
					phase <= phase + 2'h1;
					case (phase)
					2'h0: begin
						pins.ale <= 1'b1;
						pins.dq_out <= addr_byte(cur, cur.op == NFH_OP_ERASE ?
							acnt + 3'h2 : acnt);
						pins.dq_oe <= 1'b1;
						pins.we_n <= 1'b0;
					end
					2'h1: pins.we_n <= 1'b1;
					default: begin
						phase <= 2'h0;
						acnt <= acnt + 3'h1;
						if (acnt == (cur.op == NFH_OP_ERASE ? 3'h2 :
							`NFH_ADDR_CYCLES - 3'h1)) begin
							pins.ale <= 1'b0;
							pins.dq_oe <= 1'b0;
							st <= cur.op == NFH_OP_PROG ? S_WDATA : S_CMD2;
						end
					end
					endcase
				end
			end
			// only the confirm command follows data input
			S_WDATA: begin
				if (tick) begin
					phase <= phase + 2'h1;
					case (phase)
					2'h0: begin
						pins.dq_out <= wr_data;
						pins.dq_oe <= 1'b1;
						pins.we_n <= 1'b0;
						wr_take <= 1'b1;
					end
					2'h1: pins.we_n <= 1'b1;
					default: begin
						phase <= 2'h0;
						if (wr_last) begin
							pins.dq_oe <= 1'b0;
							st <= S_CMD2;
						end
					end
					endcase
				end
			end
			S_WAIT: begin
				if (tick && phase == 2'h0)
					phase <= 2'h1;
				else if (tick && (rb_s || cmd == `NFH_CMD_STATUS)) begin
					phase <= 2'h0;
					if ((cur.op == NFH_OP_PROG || cur.op == NFH_OP_ERASE) &&
						!stat_after) begin
						cmd <= `NFH_CMD_STATUS;
						stat_after <= 1'b1;
						st <= S_CMD;
					end else if (cmd == `NFH_CMD_STATUS)
						st <= S_STAT;
					else if (cur.op == NFH_OP_RESET)
						st <= S_DONE;
					else
						st <= S_RDATA;
				end
			end
			S_STAT: begin
				if (tick) begin
					phase <= phase + 2'h1;
					case (phase)
					2'h0: pins.re_n <= 1'b0;
					2'h1: begin
						pins.re_n <= 1'b1;
						rd_data <= dq_s;
					end
					default: begin
						phase <= 2'h0;
						st <= S_DONE;
						rd_valid <= !stat_after;
						prot <= !rd_data[`NFH_ST_WP_BIT];
						if (stat_after && st_rdy && st_fail) begin
							fail <= 1'b1;
							bad_tab[cur.block] <= 1'b1;
						end
					end
					endcase
				end
			end
			S_RDATA: begin
				if (tick) begin
					phase <= phase + 2'h1;
					case (phase)
					2'h0: pins.re_n <= 1'b0;
					// bus is released after this; raw bytes, ecc downstream
					2'h1: begin
						pins.re_n <= 1'b1;
						rd_data <= dq_s;
					end
					default: begin
						phase <= 2'h0;
						rd_valid <= 1'b1;
						if (cur.op == NFH_OP_SCAN) begin
							st <= S_DONE;
							if (rd_data == `NFH_BAD_MARK) begin
								bad_tab[cur.block] <= 1'b1;
								bad_block <= 1'b1;
							end
						end else if (rd_last)
							st <= S_DONE;
					end
					endcase
				end
			end
			S_DONE: begin
				pins.ce_n <= 1'b1;
				done <= 1'b1;
				req_ready <= 1'b1;
				st <= S_IDLE;
				if (cur.op == NFH_OP_ERASE && !fail)
					page_used[cur.block] <= 1'b0;
				if (cur.op == NFH_OP_PROG) begin
					page_used[cur.block] <= 1'b1;
					part_cnt <= (part_blk == cur.block &&
						part_page == cur.page) ? part_cnt + 3'h1 : 3'h1;
					part_blk <= cur.block;
					part_page <= cur.page;
				end
			end
			default: st <= S_INIT;
			endcase
		end
	end
	always_ff @(posedge clock) begin
		if (clk_en && st == S_DONE && cur.op == NFH_OP_PROG)
			last_page[cur.block] <= cur.page;
	end
	AST_NO_ERASE_BAD: assert property (@(posedge clock) disable iff (sys_rst)
		accept |-> !(req.op == NFH_OP_ERASE && is_bad))
		else $error("erase issued to bad block");
	AST_BUSY_CMD: assert property (@(posedge clock) disable iff (sys_rst)
		accept && !rb_s |-> req.op inside {NFH_OP_STATUS, NFH_OP_RESET})
		else $error("array command while busy");
	AST_INIT_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
		st == S_INIT |-> !pins.cle && !pins.ale)
		else $error("command during power-on init");
	sequence s_back_idle;
		done && req_ready && pins.ce_n;
	endsequence
	AST_DONE_IDLE: assert property (
		@(posedge clock) disable iff (sys_rst)
		st == S_DONE && clk_en |=> s_back_idle)
		else $error("no return to idle after done");
	AST_ORDER: assert property (
		@(posedge clock) disable iff (sys_rst)
		accept && req.op == NFH_OP_PROG |-> order_ok)
		else $error("program page out of order");
	AST_PARTIAL: assert property (
		@(posedge clock) disable iff (sys_rst)
		accept && req.op == NFH_OP_PROG |-> part_ok)
		else $error("too many partial programs");
	AST_REFUSE: assert property (
		@(posedge clock) disable iff (sys_rst)
		reject && clk_en |=> refused)
		else $error("refusal not reported");
endmodule // nfh_host
`default_nettype wire

// ---- testbench/nfh_dev_model.sv ----
// behavioural nand flash device answering the host pins
`timescale 1ns/100ps
`default_nettype none
module nfh_dev_model #(
	parameter int          INIT_CYC = 40,
	parameter int          OP_CYC   = 30,
	parameter logic [10:0] BAD_BLK  = 11'h005
) (
	input  wire logic               clock,
	input  wire nfh_pkg::nfh_pins_s pins,
	input  wire logic               fail_next,
	output logic [7:0]              dq_drv = 8'h00,
	output logic                    rb_low,
	output int                      viol = 0
);
	int         busy_cnt = INIT_CYC;
	logic       busy_op  = 1'b0;
	logic       in_prog  = 1'b0;
	logic       stat     = 1'b0;
	logic       st_fail  = 1'b0;
	logic       is_erase = 1'b0;
	logic       we_q     = 1'b1;
	logic [7:0] adr [0:4];
	int         nadr     = 0;
	logic [7:0] last_q   = 8'h00;
	wire [7:0]  c        = pins.dq_out;
	wire        strobe   = !pins.ce_n && pins.we_n && !we_q;
	wire        rdy      = busy_cnt == 0;
	wire [23:0] row      = is_erase ? {adr[2], adr[1], adr[0]}
		: {adr[4], adr[3], adr[2]};
	wire        hit_bad  = row[16:6] == BAD_BLK;
	wire [7:0]  stat_b   = {pins.wp_n, rdy, rdy, 4'h0, st_fail};
	wire [7:0]  out_b    = stat ? stat_b : (hit_bad ? 8'h00 : 8'hA5);
	assign rb_low = busy_cnt > 0; // only ever pulls low
	always @(posedge clock) begin
		we_q <= pins.we_n;
		if (busy_cnt > 0)
			busy_cnt <= busy_cnt - 1;
		if (!pins.wp_n && busy_op && busy_cnt > 0)
			busy_cnt <= 0;
		if (!pins.ce_n && !pins.re_n) begin
			dq_drv <= out_b;
			last_q <= out_b;
		end else
			dq_drv <= ~last_q; // released bus never shows a stale byte
		if (strobe && pins.ale) begin
			if (nadr < 5)
				adr[nadr] <= c;
			nadr <= nadr + 1;
		end
		if (strobe && pins.cle) begin
			if (!(c inside {8'h00, 8'h30, 8'h80, 8'h85, 8'h10, 8'h11,
				8'h15, 8'h60, 8'hD0, 8'h70, 8'h71, 8'hFF}))
				viol <= viol + 1;
			if (busy_cnt > 0 && !(c inside {8'h70, 8'h71, 8'hFF}))
				viol <= viol + 1;
			if (in_prog && !(c inside {8'h85, 8'h10, 8'h11, 8'h15, 8'hFF}))
				viol <= viol + 1;
			in_prog <= c == 8'h80 || (in_prog && c == 8'h85);
			if (c == 8'h70 || c == 8'h71)
				stat <= 1'b1;
			if (c == 8'h00)
				stat <= 1'b0; // status mode off; a new address follows
			if (c == 8'h00 || c == 8'h80 || c == 8'h60) begin
				nadr <= 0;
				is_erase <= c == 8'h60;
			end
			if (c == 8'h10 || c == 8'hD0 || c == 8'h30) begin
				busy_cnt <= OP_CYC;
				busy_op <= c != 8'h30;
				st_fail <= c != 8'h30 && fail_next;
			end
			if (c == 8'hD0 && hit_bad)
				viol <= viol + 1;
			if (c == 8'hFF) begin
				busy_cnt <= 2;
				busy_op <= 1'b0;
				st_fail <= 1'b0;
			end
		end
	end
endmodule // nfh_dev_model
`default_nettype wire

// ---- testbench/nand_command_usage_rules_tb.sv ----
// self-checking bench for the nand host sequencer
`timescale 1ns/100ps
`default_nettype none
module nand_command_usage_rules_tb;
	import nfh_pkg::*;
	logic       clock = 1'b0;
	logic       sys_rst = 1'b1;
	nfh_req_s   req = '0;
	logic       req_valid = 1'b0;
	logic       fail_next = 1'b0;
	logic       req_ready, wr_take, rd_valid, done, fail;
	logic       refused, bad_block, prot, rb_low;
	logic [7:0] rd_data, dq_drv;
	logic [7:0] last_rd = 8'h00;
	nfh_pins_s  pins;
	int         viol;
	int         widx = 0;
	int         cyc = 0;
	int         n_errors = 0;
	int         check_count = 0;
	wire        ready_busy_n = !rb_low; // board pull-up
	nfh_host dut (
		.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .req(req),
		.req_valid(req_valid), .req_ready(req_ready),
		.wr_data(widx[7:0]), .wr_last(widx[0]), .wr_take(wr_take),
		.rd_data(rd_data), .rd_valid(rd_valid), .rd_last(1'b1),
		.done(done), .fail(fail), .refused(refused),
		.bad_block(bad_block), .prot(prot), .pins(pins),
		.dq_in(dq_drv), .ready_busy_n(ready_busy_n));
	nfh_dev_model #(.BAD_BLK(11'h005)) dev (.clock(clock), .pins(pins),
		.fail_next(fail_next), .dq_drv(dq_drv), .rb_low(rb_low),
		.viol(viol));
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (wr_take === 1'b1)
			widx <= widx + 1;
		if (rd_valid === 1'b1)
			last_rd <= rd_data;
		if (cyc == 40000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic op(input nfh_op_e k, input int blk, input int pg,
		input logic part, input logic ok);
		int n;
		logic d;
		logic r;
		@(negedge clock);
		req = '{k, blk[10:0], pg[5:0], 13'h0000, part};
		req_valid = 1'b1;
		for (n = 0; n < 500 && req_ready !== 1'b1; n++)
			@(negedge clock);
		d = 1'b0;
		r = 1'b0;
		for (n = 0; n < 5000 && !d && !r; n++) begin
			@(negedge clock);
			d = done === 1'b1;
			r = refused === 1'b1;
			if (req_ready !== 1'b1 || r)
				req_valid = 1'b0;
		end
		chk(d === ok && r === !ok, "operation outcome");
	endtask
	task automatic t_power();
		int n;
		repeat (6) @(negedge clock);
		chk(req_ready === 1'b0, "ready during init");
		for (n = 0; n < 200 && req_ready !== 1'b1; n++)
			@(negedge clock);
		chk(req_ready === 1'b1, "never ready");
		$display("power test done");
	endtask
	task automatic t_prog();
		op(NFH_OP_PROG, 1, 0, 1'b0, 1'b1);
		chk(fail === 1'b0, "program failed");
		op(NFH_OP_PROG, 1, 0, 1'b0, 1'b0);
		op(NFH_OP_PROG, 1, 1, 1'b0, 1'b1);
		$display("order test done");
	endtask
	task automatic t_partial();
		repeat (4) op(NFH_OP_PROG, 2, 0, 1'b1, 1'b1);
		op(NFH_OP_PROG, 2, 0, 1'b1, 1'b0);
		$display("partial test done");
	endtask
	task automatic t_bad();
		op(NFH_OP_SCAN, 6, 0, 1'b0, 1'b1);
		chk(bad_block === 1'b0, "good block flagged");
		op(NFH_OP_SCAN, 5, 0, 1'b0, 1'b1);
		chk(bad_block === 1'b1, "bad block missed");
		op(NFH_OP_ERASE, 5, 0, 1'b0, 1'b0);
		op(NFH_OP_PROG, 5, 0, 1'b0, 1'b0);
		$display("bad block test done");
	endtask
	task automatic t_fail();
		fail_next = 1'b1;
		op(NFH_OP_PROG, 3, 0, 1'b0, 1'b1);
		chk(fail === 1'b1, "failure not seen");
		fail_next = 1'b0;
		op(NFH_OP_PROG, 3, 1, 1'b0, 1'b0);
		op(NFH_OP_PROG, 4, 0, 1'b0, 1'b1);
		chk(fail === 1'b0, "failure stuck");
		$display("failure test done");
	endtask
	task automatic t_misc();
		op(NFH_OP_ERASE, 1, 0, 1'b0, 1'b1);
		op(NFH_OP_PROG, 1, 0, 1'b0, 1'b1);
		op(NFH_OP_STATUS, 0, 0, 1'b0, 1'b1);
		chk(last_rd === 8'hE0, "status byte");
		chk(prot === 1'b0, "protect flag");
		op(NFH_OP_RESET, 0, 0, 1'b0, 1'b1);
		op(NFH_OP_READ, 1, 0, 1'b0, 1'b1);
		chk(last_rd === 8'hA5, "read data");
		$display("misc test done");
	endtask
	initial begin
		repeat (4) @(negedge clock);
		sys_rst = 1'b0;
		t_power();
		t_prog();
		t_partial();
		t_bad();
		t_fail();
		t_misc();
		chk(viol == 0, "illegal command seen");
		close_out();
	end
endmodule // nand_command_usage_rules_tb
`default_nettype wire
